// [sim/sfe_host.sv]
/* SPI host model: drives select, serial clock, reset pin and lanes, and samples returned bits.
   Assumes a 50 MHz bench clock; a serial clock half period is four of its cycles. */
`timescale 1ns/1ps
module sfe_host (
    input  wire logic          clk,
    input  wire logic [3:0]    laneOut,
    input  wire logic [3:0]    laneOeB,
    output sfe_pkg::sfe_pins_t pins
);
    import sfe_pkg::*;
    logic       csB = 1'b0;   // Low from power-up, so no frame may start before a fall.
    logic       sck = 1'b0;
    logic       rstB = 1'b1;
    logic       mode3 = 1'b0; // Idle clock level, high in mode 3.
    logic       wpB = 1'b1;
    logic [3:0] oe = 4'hd;    // High where the host drives a lane.
    logic [3:0] drv = 4'hd;
    logic [3:0] lanes;
    // A lane nobody drives shows the inverse of the last host value, so a stale copy never passes.
    assign lanes = (~laneOeB & laneOut) | (laneOeB & oe & drv) | (laneOeB & ~oe & ~drv);
    assign pins = {csB, sck, rstB, lanes};
    // Per group of w bits: fall, drive, rise, then sample late in the high half.
    task automatic step(input logic [31:0] v, input int n, input int w, input int lo, input logic [3:0] o,
                        output logic [31:0] got);
        got = '0;
        for (int i = n - w; i >= 0; i -= w)
        begin
            @(negedge clk);
            sck = 1'b0;
            oe = o;
            for (int k = 0; k < w; k++)
                drv[k] = v[i + k];
            repeat (4) @(negedge clk);
            sck = 1'b1;
            repeat (3) @(negedge clk);
            for (int k = w - 1; k >= 0; k--)
                got = {got[30:0], lanes[lo + k]};
        end
    endtask
    // Select falls only with the clock at its idle level.
    task automatic head(input logic [7:0] op, input logic [23:0] a, input int n, input int aw);
        logic [31:0] got;
        @(negedge clk);
        oe = 4'hd;
        drv = {1'b1, wpB, 2'b01};
        sck = mode3;
        repeat (2) @(negedge clk);
        csB = 1'b0;
        repeat (4) @(negedge clk);
        step(op, 8, 1, 0, 4'hd, got);
        step(a, n, aw, 0, aw == 1 ? 4'hd : 4'hf, got);
    endtask
    // The clock returns to idle before select rises.
    task automatic tail();
        repeat (4) @(negedge clk);
        sck = mode3;
        repeat (4) @(negedge clk);
        csB = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    // A frame that carries an opcode alone.
    task automatic cmd(input logic [7:0] op);
        head(op, 24'h0, 0, 1);
        tail();
    endtask
endmodule

// [sim/tb_top.sv]
/* Self-checking bench: the host model runs frames and the bench compares what comes back.
   Assumes the design samples every pin with its own 50 MHz clock. */
`timescale 1ns/1ps
module tb_top;
    import sfe_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0, quadEnable = 1'b0, statusProtect = 1'b0, busy;
    logic [3:0]  laneOut, laneOeB;
    logic [7:0]  readByte;
    logic [23:0] readAddr;
    logic [31:0] got;
    sfe_pins_t   pins;
    sfe_event_t  evt;
    int          n_errors = 0, checks_done = 0, nOps = 0, nStat = 0, k;
    // Array stand-in: the low address byte scrambled, so a wrong address shows.
    assign readByte = readAddr[7:0] ^ 8'h5a;
    sfe_front_end sfe_front_end_inst (.clk(clk), .rst_b(rst_b), .pins(pins), .quadEnable(quadEnable),
        .statusProtect(statusProtect), .readByte(readByte), .statusByte(8'ha5), .laneOut(laneOut),
        .laneOeB(laneOeB), .evt(evt), .readAddr(readAddr), .busy(busy));
    sfe_host sfe_host_inst (.clk(clk), .laneOut(laneOut), .laneOeB(laneOeB), .pins(pins));
    // Free-running bench clock.
    initial forever #10 clk = ~clk;
    // Counts accepted opcodes and granted status writes.
    always @(posedge clk)
    begin
        nOps += int'(evt.opcodeValid === 1'b1);
        nStat += int'(evt.statusWrite === 1'b1);
    end
    // Compares one value and counts it.
    task automatic check(input logic [31:0] a, input logic [31:0] e);
        checks_done++;
        if (a !== e)
            $display("ERROR %0t got %h expected %h", $time, a, e);
        n_errors += int'(a !== e);
    endtask
    // Prints the verdict and stops the run.
    task automatic end_sim();
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One two-byte read frame; ok tells whether the device must answer it.
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int aw, input int dm, input int dw,
                      input logic [3:0] oeD, input logic ok);
        sfe_host_inst.head(op, a, 24, aw);
        sfe_host_inst.step(0, dm, 1, 0, aw == 1 ? 4'hd : 4'hf, got);
        sfe_host_inst.step(0, 16, dw, int'(dw == 1), oeD, got);
        check(laneOeB, ok ? oeD : OE_OFF);
        if (ok)
            check(got[15:0], {a[7:0] ^ 8'h5a, (a[7:0] + 8'h1) ^ 8'h5a});
        sfe_host_inst.tail();
        check(laneOeB, OE_OFF);
    endtask
    // Main sequence.
    initial
    begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        sfe_host_inst.step(OP_RD_STAT, 8, 1, 0, 4'hd, got);
        check(nOps, 0);
        sfe_host_inst.tail();
        rd(OP_READ, 24'h0000fe, 1, 0, 1, OE_SINGLE, 1'b1);
        rd(OP_FAST, 24'h12347f, 1, 8, 1, OE_SINGLE, 1'b1);
        rd(OP_DUAL_OUT, 24'h00ff10, 1, 8, 2, OE_DUAL, 1'b1);
        rd(OP_DUAL_IO, 24'h0a0bc3, 2, 4, 2, OE_DUAL, 1'b1);
        rd(OP_QUAD_OUT, 24'h00003f, 1, 8, 4, OE_QUAD, 1'b0);
        rd(OP_QUAD_IO, 24'h000040, 4, 6, 4, OE_QUAD, 1'b0);
        quadEnable = 1'b1;
        rd(OP_QUAD_OUT, 24'h000041, 1, 8, 4, OE_QUAD, 1'b1);
        rd(OP_QUAD_IO, 24'h5a5a99, 4, 6, 4, OE_QUAD, 1'b1);
        quadEnable = 1'b0;
        sfe_host_inst.mode3 = 1'b1;
        rd(OP_READ, 24'h00a5ff, 1, 0, 1, OE_SINGLE, 1'b1);
        sfe_host_inst.mode3 = 1'b0;
        // Status read returns the status byte; a program frame hands over address and data.
        sfe_host_inst.head(OP_RD_STAT, 24'h0, 0, 1);
        sfe_host_inst.step(0, 8, 1, 1, 4'hd, got);
        check(got, 32'h000000a5);
        sfe_host_inst.tail();
        sfe_host_inst.head(OP_PROG, 24'h00c0de, 24, 1);
        sfe_host_inst.step(8'h96, 8, 1, 0, 4'hd, got);
        sfe_host_inst.tail();
        check(evt.address, 24'h00c0de);
        check(evt.dataByte, 8'h96);
        // Pause in mid-byte, with and without quad enable, then resume the same byte.
        for (int q = 0; q < 2; q++)
        begin
            quadEnable = q[0];
            sfe_host_inst.head(OP_READ, 24'h000030, 24, 1);
            sfe_host_inst.step(0, 4, 1, 1, 4'hd, got);
            sfe_host_inst.drv[3] = 1'b0;
            repeat (8) @(negedge clk);
            check(laneOeB, q ? OE_SINGLE : OE_OFF);
            sfe_host_inst.drv[3] = 1'b1;
            repeat (8) @(negedge clk);
            sfe_host_inst.step(0, 12, 1, 1, 4'hd, got);
            check(got, 32'h00000a6b);
            sfe_host_inst.tail();
        end
        quadEnable = 1'b0;
        statusProtect = 1'b1;
        for (int g = 0; g < 2; g++)
        begin
            k = nStat;
            sfe_host_inst.wpB = g[0];
            sfe_host_inst.head(OP_WR_STAT, 24'h3c, 8, 1);
            sfe_host_inst.tail();
            check(nStat - k, g);
        end
        sfe_host_inst.cmd(OP_RST);
        check(busy, 1'b0);
        sfe_host_inst.cmd(OP_RST_EN);
        sfe_host_inst.cmd(OP_RST);
        check(busy, 1'b1);
        k = nOps;
        sfe_host_inst.cmd(OP_READ);
        check(nOps, k);
        for (k = 0; k < 2000 && busy !== 1'b0; k++)
            @(negedge clk);
        check(k > 1200 && k < 1500, 1'b1);
        k = nOps;
        sfe_host_inst.cmd(OP_RST_EN);
        check(nOps, k + 1);
        sfe_host_inst.cmd(OP_RST);
        sfe_host_inst.head(OP_READ, 24'h000100, 24, 1);
        sfe_host_inst.step(0, 4, 1, 1, 4'hd, got);
        sfe_host_inst.rstB = 1'b0;
        repeat (50) @(negedge clk);
        check(laneOeB, OE_OFF);
        check(busy, 1'b0);
        sfe_host_inst.rstB = 1'b1;
        sfe_host_inst.tail();
        rd(OP_READ, 24'h000200, 1, 0, 1, OE_SINGLE, 1'b1);
        end_sim();
    end
    // Watchdog: the whole sequence needs well under 60000 cycles.
    initial
    begin
        repeat (60000) @(posedge clk);
        n_errors++;
        end_sim();
    end
endmodule

// [verilog/sfe_front_end.sv]
/*
 * Serial host front end of a serial flash: decodes frames, captures opcode,
 * address and write data, and returns read data on one, two or four lanes.
 * Assumes the array side answers readByte for readAddr within two clocks.
 */
// Notes on behaviour
// - Deselected means every lane output floats.
// - Single lane input sampled on clock rise.
// - Single lane output changes on clock fall.
// - Wide modes sample on rise, drive on fall.
// - Quad opcodes need quad enable; lanes remap.
// - Pause floats outputs and freezes the link.
// - Quad enable disables the pause function.
// - Write guard with protect bit blocks status writes, unless quad enable is set.
// - Reset pin low returns the state, lane drivers and software reset to power-on values.
// - Software reset needs enable then reset opcode.
// - Software reset rejects opcodes while recovering.
// - Reset pin overrides all other link inputs.
// - Clock idle level may be low or high.
// - Dual read opcodes use lanes zero and one.
// - Quad read opcodes use all four lanes.
`timescale 1ns/1ps
module sfe_front_end
    import sfe_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire sfe_pkg::sfe_pins_t pins,
    input  wire logic              quadEnable,
    input  wire logic              statusProtect,
    input  wire logic [7:0]        readByte,
    input  wire logic [7:0]        statusByte,
    output logic      [3:0]        laneOut,
    output logic      [3:0]        laneOeB,
    output sfe_pkg::sfe_event_t    evt,
    output logic      [23:0]       readAddr,
    output logic                   busy
);
    import sfe_pkg::*;

    sfe_pins_t          inS;
    logic [6:0]         syncOut;
    sfe_state_t         state_q;
    sfe_decode_t        dec_q;
    logic [4:0]         cnt_q;
    logic [23:0]        shiftIn_q;
    logic [7:0]         outShift_q;
    logic [4:0]         outCnt_q;
    logic               sclkPrev_q;
    logic               csPrev_q;
    logic               rstEnable_q;
    logic [BUSY_W-1:0]  busyCnt_q;
    logic               sclkRise;
    logic               sclkFall;
    logic               csFall;
    logic               holdAct;
    logic               abort;
    logic               statusWriteOk;
    logic [23:0]        shNext;
    logic [7:0]         src;
    sfe_decode_t        opDec;

    // ----------------------------------------------------------------------
    // Pin synchronisation and edge finding
    // ----------------------------------------------------------------------
    sfe_sync3 #(.W(7)) uSync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (pins),
        .dout  (syncOut)
    );
    assign inS = sfe_pins_t'(syncOut);

    // Edge history is kept on synchronised copies only.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclkPrev_q <= 1'b0;
            csPrev_q   <= 1'b0;
        end
        else
        begin
            sclkPrev_q <= inS.sclk;
            csPrev_q   <= inS.chipSelB;
        end
    end

    // Either clock idle level works: a frame only acts on edges seen while selected.
    assign sclkRise = inS.sclk & ~sclkPrev_q;
    assign sclkFall = ~inS.sclk & sclkPrev_q;
    // The synchroniser resets low, so a chip select already low at power-up is no fall.
    assign csFall   = ~inS.chipSelB & csPrev_q;
    assign abort    = ~inS.hwResetB;
    // Pause only counts while selected and only without quad enable.
    assign holdAct  = ~quadEnable & ~inS.laneIn[3] & ~inS.chipSelB;
    // In quad mode lane 2 carries data, so it cannot act as write guard.
    assign statusWriteOk = ~(statusProtect & ~quadEnable & ~inS.laneIn[2]);

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    function automatic logic [23:0] shiftLanes(input logic [1:0] w, input logic [23:0] s, input logic [3:0] l);
        case (w)
            W1:      return {s[22:0], l[0]};
            W2:      return {s[21:0], l[1:0]};
            default: return {s[19:0], l};
        endcase
    endfunction

    function automatic sfe_decode_t decodeOp(input logic [7:0] op);
        sfe_decode_t d;
        d = '0;
        d.known = 1'b1;
        case (op)
            OP_READ:     begin d.hasAddr = 1'b1; d.isRead = 1'b1; end
            OP_FAST:     begin d.hasAddr = 1'b1; d.isRead = 1'b1; d.dummy = DUMMY_FAST; end
            OP_DUAL_OUT: begin d.hasAddr = 1'b1; d.isRead = 1'b1; d.dummy = DUMMY_FAST; d.dataW = W2; end
            OP_DUAL_IO:  begin d.hasAddr = 1'b1; d.isRead = 1'b1; d.dummy = DUMMY_DIO; d.dataW = W2;
                               d.addrW = W2; end
            OP_QUAD_OUT: begin d.hasAddr = 1'b1; d.isRead = 1'b1; d.dummy = DUMMY_FAST; d.dataW = W4;
                               d.quad = 1'b1; end
            OP_QUAD_IO:  begin d.hasAddr = 1'b1; d.isRead = 1'b1; d.dummy = DUMMY_QIO; d.dataW = W4;
                               d.addrW = W4; d.quad = 1'b1; end
            OP_PROG:     begin d.hasAddr = 1'b1; d.isWrite = 1'b1; end
            OP_WR_STAT:  begin d.isWrite = 1'b1; d.isStatus = 1'b1; end
            OP_RD_STAT:  begin d.isRead = 1'b1; d.isStatus = 1'b1; end
            OP_RST_EN,
            OP_RST:      d.known = 1'b1;
            default:     d.known = 1'b0;
        endcase
        return d;
    endfunction

    // ----------------------------------------------------------------------
    // Frame sequencing and input capture
    // ----------------------------------------------------------------------
    always_comb
    begin
        shNext = shiftIn_q;
        case (state_q)
            S_OPCODE: shNext = shiftLanes(W1, shiftIn_q, inS.laneIn);
            S_ADDR:   shNext = shiftLanes(dec_q.addrW, shiftIn_q, inS.laneIn);
            S_DIN:    shNext = shiftLanes(W1, shiftIn_q, inS.laneIn);
            default:  shNext = shiftIn_q;
        endcase
    end

    // One decode of the byte that would be complete at this rising edge.
    assign opDec = decodeOp(shNext[7:0]);

    // Every rising edge while selected, not paused and out of idle advances the frame.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q   <= S_IDLE;
            dec_q     <= '0;
            cnt_q     <= '0;
            shiftIn_q <= '0;
            evt       <= '0;
        end
        else
        begin
            evt.opcodeValid <= 1'b0;
            evt.addrValid   <= 1'b0;
            evt.dataValid   <= 1'b0;
            evt.statusWrite <= 1'b0;
            if (abort)
                state_q <= S_IDLE;
            else if (inS.chipSelB)
                state_q <= S_IDLE;
            else if (csFall)
            begin
                state_q <= S_OPCODE;
                cnt_q   <= BYTE_BITS;
            end
            else if (sclkRise && !holdAct && state_q != S_IDLE)
            begin
                shiftIn_q <= shNext;
                cnt_q     <= cnt_q - 5'h01;
                case (state_q)
                    S_OPCODE:
                        if (cnt_q == 5'h01)
                        begin
                            dec_q      <= opDec;
                            evt.opcode <= shNext[7:0];
                            evt.opcodeValid <= ~busy;
                            if (busy || !opDec.known)
                                state_q <= S_IGNORE;
                            else if (opDec.quad && !quadEnable)
                                state_q <= S_IGNORE;
                            else if (opDec.hasAddr)
                            begin
                                state_q <= S_ADDR;
                                cnt_q   <= ADDR_BITS >> opDec.addrW;
                            end
                            else if (opDec.isRead)
                                state_q <= S_DOUT;
                            else if (opDec.isWrite)
                            begin
                                state_q <= S_DIN;
                                cnt_q   <= BYTE_BITS;
                            end
                            else
                                state_q <= S_IGNORE;
                        end
                    S_ADDR:
                        if (cnt_q == 5'h01)
                        begin
                            evt.address   <= shNext;
                            evt.addrValid <= 1'b1;
                            cnt_q         <= {1'b0, dec_q.dummy};
                            if (dec_q.dummy != 4'h0)
                                state_q <= S_DUMMY;
                            else if (dec_q.isRead)
                                state_q <= S_DOUT;
                            else
                            begin
                                state_q <= S_DIN;
                                cnt_q   <= BYTE_BITS;
                            end
                        end
                    S_DUMMY:
                        if (cnt_q == 5'h01)
                            state_q <= S_DOUT;
                    S_DIN:
                        if (cnt_q == 5'h01)
                        begin
                            cnt_q        <= BYTE_BITS;
                            evt.dataByte <= shNext[7:0];
                            evt.dataValid   <= ~dec_q.isStatus;
                            evt.statusWrite <= dec_q.isStatus & statusWriteOk;
                        end
                    default:
                        cnt_q <= cnt_q;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------------
    // Read data return
    // ----------------------------------------------------------------------
    assign src = (outCnt_q == 5'h00) ? (dec_q.isStatus ? statusByte : readByte) : outShift_q;

    // New bits go out on falling edges so the host samples them on the next rise.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            laneOut    <= 4'h0;
            laneOeB    <= OE_OFF;
            outShift_q <= 8'h00;
            outCnt_q   <= 5'h00;
            readAddr   <= 24'h000000;
        end
        else if (abort || inS.chipSelB || state_q != S_DOUT)
        begin
            // Drivers stay off outside the return phase.
            laneOeB  <= OE_OFF;
            outCnt_q <= 5'h00;
            if (abort)
                laneOut <= 4'h0;
            if (evt.addrValid)
                readAddr <= evt.address;
        end
        else if (evt.addrValid)
            // A read without dummy clocks enters the return phase together with its address.
            readAddr <= evt.address;
        else if (holdAct)
            // A pause floats the lanes but keeps the bit position, so the byte resumes where it stopped.
            laneOeB <= OE_OFF;
        else if (sclkFall)
        begin
            outCnt_q <= ((outCnt_q == 5'h00) ? (BYTE_BITS >> dec_q.dataW) : outCnt_q) - 5'h01;
            if (outCnt_q == 5'h00 && !dec_q.isStatus)
                readAddr <= readAddr + 24'h000001;
            case (dec_q.dataW)
                W1:
                begin
                    laneOut    <= {2'b00, src[7], 1'b0};
                    laneOeB    <= OE_SINGLE;
                    outShift_q <= {src[6:0], 1'b0};
                end
                W2:
                begin
                    laneOut    <= {2'b00, src[7:6]};
                    laneOeB    <= OE_DUAL;
                    outShift_q <= {src[5:0], 2'b00};
                end
                default:
                begin
                    laneOut    <= src[7:4];
                    laneOeB    <= OE_QUAD;
                    outShift_q <= {src[3:0], 4'h0};
                end
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // Software reset
    // ----------------------------------------------------------------------
    // The enable latch only survives into the very next opcode.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstEnable_q <= 1'b0;
            busyCnt_q   <= '0;
            busy        <= 1'b0;
        end
        else if (abort)
        begin
            rstEnable_q <= 1'b0;
            busyCnt_q   <= '0;
            busy        <= 1'b0;
        end
        else
        begin
            // The busy flag is kept in step with the counter so the port comes from a flip-flop.
            if (busy)
            begin
                busyCnt_q <= busyCnt_q - BUSY_W'(1);
                busy      <= (busyCnt_q != BUSY_W'(1));
            end
            if (evt.opcodeValid)
            begin
                rstEnable_q <= (evt.opcode == OP_RST_EN);
                if (evt.opcode == OP_RST && rstEnable_q)
                begin
                    busyCnt_q <= BUSY_W'(TRST_CYC);
                    busy      <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    property p_desel_float;
        @(posedge clk) disable iff (!rst_b) inS.chipSelB |=> laneOeB == OE_OFF;
    endproperty
    a_desel_float: assert property (p_desel_float) else $error("Lane driven while deselected.");

    property p_rise_capture;
        @(posedge clk) disable iff (!rst_b) $changed(shiftIn_q) |-> $past(sclkRise);
    endproperty
    a_rise_capture: assert property (p_rise_capture) else $error("Input captured off a rising edge.");

    property p_fall_drive;
        @(posedge clk) disable iff (!rst_b) $changed(laneOut) |-> $past(sclkFall) || $past(abort);
    endproperty
    a_fall_drive: assert property (p_fall_drive) else $error("Output changed off a falling edge.");

    property p_no_quad;
        @(posedge clk) disable iff (!rst_b) !quadEnable && $past(!quadEnable, 2) |-> laneOeB[3:2] == 2'b11;
    endproperty
    a_no_quad: assert property (p_no_quad) else $error("Upper lanes driven without quad enable.");

    property p_pause_float;
        @(posedge clk) disable iff (!rst_b) holdAct |=> laneOeB == OE_OFF;
    endproperty
    a_pause_float: assert property (p_pause_float) else $error("Lane driven during pause.");

    property p_guard;
        @(posedge clk) disable iff (!rst_b) evt.statusWrite |-> $past(statusWriteOk);
    endproperty
    a_guard: assert property (p_guard) else $error("Status write passed a guarded pin.");

    property p_sw_seq;
        @(posedge clk) disable iff (!rst_b) $rose(busy) |-> $past(rstEnable_q) && $past(evt.opcode) == OP_RST;
    endproperty
    a_sw_seq: assert property (p_sw_seq) else $error("Recovery began without the two-opcode sequence.");

    property p_sw_busy;
        @(posedge clk) disable iff (!rst_b || abort) $rose(busy) |-> (busy && !evt.opcodeValid)[*8];
    endproperty
    a_sw_busy: assert property (p_sw_busy) else $error("Recovery ended early or accepted an opcode.");

    property p_pin_reset;
        @(posedge clk) disable iff (!rst_b) abort |=> state_q == S_IDLE && laneOeB == OE_OFF && !busy;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("Reset pin did not restore power-on state.");
endmodule

// [verilog/sfe_pkg.sv]
/*
 * Shared constants, opcodes and carrier types for the serial flash front end.
 * Assumes a 50 MHz system clock that samples every pin of the serial link.
 */
package sfe_pkg;

    // ----------------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------------
    localparam int CLK_MHZ   = 50;
    localparam int TRST_US   = 30;                  // Software reset recovery, microseconds.
    localparam int TRST_CYC  = TRST_US * CLK_MHZ;   // Whole cycles of recovery.
    localparam int BUSY_W    = 11;

    // ----------------------------------------------------------------------
    // Opcodes
    // ----------------------------------------------------------------------
    localparam logic [7:0] OP_WR_STAT  = 8'h01;
    localparam logic [7:0] OP_PROG     = 8'h02;
    localparam logic [7:0] OP_READ     = 8'h03;
    localparam logic [7:0] OP_RD_STAT  = 8'h05;
    localparam logic [7:0] OP_FAST     = 8'h0b;
    localparam logic [7:0] OP_DUAL_OUT = 8'h3b;
    localparam logic [7:0] OP_RST_EN   = 8'h66;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
    localparam logic [7:0] OP_RST      = 8'h99;
    localparam logic [7:0] OP_DUAL_IO  = 8'hbb;
    localparam logic [7:0] OP_QUAD_IO  = 8'heb;

    // ----------------------------------------------------------------------
    // Lane widths, phase lengths and reset values
    // ----------------------------------------------------------------------
    localparam logic [1:0] W1          = 2'h0;
    localparam logic [1:0] W2          = 2'h1;
    localparam logic [1:0] W4          = 2'h2;
    localparam logic [4:0] ADDR_BITS   = 5'h18;
    localparam logic [4:0] BYTE_BITS   = 5'h08;
    localparam logic [3:0] DUMMY_FAST  = 4'h8;
    localparam logic [3:0] DUMMY_DIO   = 4'h4;
    localparam logic [3:0] DUMMY_QIO   = 4'h6;
    localparam logic [3:0] OE_OFF      = 4'hf;
    localparam logic [3:0] OE_SINGLE   = 4'hd;
    localparam logic [3:0] OE_DUAL     = 4'hc;
    localparam logic [3:0] OE_QUAD     = 4'h0;
    localparam logic [6:0] SYNC_RST    = 7'h00;

    // ----------------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic       chipSelB;
        logic       sclk;
        logic       hwResetB;
        logic [3:0] laneIn;     // Lane 2 doubles as write guard, lane 3 as pause.
    } sfe_pins_t;

    typedef struct packed {
        logic        opcodeValid;
        logic [7:0]  opcode;
        logic        addrValid;
        logic [23:0] address;
        logic        dataValid;
        logic [7:0]  dataByte;
        logic        statusWrite;
    } sfe_event_t;

    typedef struct packed {
        logic       known;
        logic       quad;
        logic       hasAddr;
        logic [1:0] addrW;
        logic [3:0] dummy;
        logic [1:0] dataW;
        logic       isRead;
        logic       isWrite;
        logic       isStatus;
    } sfe_decode_t;

    typedef enum {S_IDLE, S_OPCODE, S_ADDR, S_DUMMY, S_DIN, S_DOUT, S_IGNORE} sfe_state_t;

endpackage

// [verilog/sfe_sync3.sv]
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes inputs are asynchronous to clk; the output moves only when the
 * second and third stages agree.
 */
`timescale 1ns/1ps
module sfe_sync3 #(
    parameter int W = 7
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // --------------------------------------------------------------------
    // Stages
    // --------------------------------------------------------------------
    // The first stage feeds nothing but the second, to contain metastability.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            dout <= '0;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            dout <= (s2_q & ~(s2_q ^ s3_q)) | (dout & (s2_q ^ s3_q));
        end
    end
endmodule
